// ==== hw/deeac_mem.sv ====
/*
 Byte array of the data EEPROM with registered read data.
 Assumes the controller never reads and writes in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module deeac_mem #(
   parameter int AW = 10,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wr_data,
   output var  logic [DW-1:0] rd_data
);
   logic [DW-1:0] cells [2**AW];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         cells[addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= cells[addr];
      end
   end
endmodule
`default_nettype wire

// ==== hw/deeac_pkg.sv ====
/*
 Constants, register map and types of the data EEPROM access control block.
 Assumes a single 10 MHz clock and an APB master with 32-bit data.
*/
// Operation
// - Read byte visible to the very next access
// - Data register holds until read or write
// - Exact unlock sequence required before each write
// - Write request ignored while writes disabled
// - Enable and request never accepted together
// - Hardware never changes the write enable
// - Control, address, data locked during write
// - Clearing enable never aborts running write
// - One byte, implicit erase before program
// - Processor keeps running during write cycle
// - Completion clears request, sets done flag
// - Done flag cleared by software only
package deeac_pkg;
   localparam int ADDR_W  = 10;
   localparam int DATA_W  = 8;
   localparam int ADRLO_W = 8;
   localparam int PADDR_W = 8;
   localparam int PDATA_W = 32;

   localparam logic [PADDR_W-1:0] OFF_ADDR_LO = 8'h00;
   localparam logic [PADDR_W-1:0] OFF_ADDR_HI = 8'h04;
   localparam logic [PADDR_W-1:0] OFF_CTRL    = 8'h08;
   localparam logic [PADDR_W-1:0] OFF_DATA    = 8'h0c;
   localparam logic [PADDR_W-1:0] OFF_UNLOCK  = 8'h10;
   localparam logic [PADDR_W-1:0] OFF_STATUS  = 8'h14;
   localparam logic [PADDR_W-1:0] OFF_MASK    = 8'h18;

   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   localparam logic [1:0] REGION_EEPROM = 2'h0;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

   // Sticky event bits of the status and mask registers, and the live busy bit of status
   localparam int EVT_N       = 2;
   localparam int EVT_DONE    = 0;
   localparam int EVT_REFUSED = 1;
   localparam int STAT_BUSY   = 2;
   localparam logic [EVT_N-1:0] EVT_RESET = 2'h0;

   localparam int CLK_PERIOD_NS = 100;
   localparam int ERASE_TIME_NS = 2000000;
   localparam int PROG_TIME_NS  = 2000000;
   localparam int ERASE_CYCLES_DEF =
      (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CYCLES_DEF =
      (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   localparam int CTRL_W = 6;
   typedef struct packed {
      logic [1:0] region;
      logic       erase_req;
      logic       write_enable_bit;
      logic       wr_req;
      logic       rd_req;
   } deeac_ctrl_t;
   localparam deeac_ctrl_t CTRL_RESET = 6'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ERASE = 3'b010,
      ST_PROG  = 3'b100
   } deeac_state_t;

   typedef enum logic [2:0] {
      UL_NONE  = 3'b001,
      UL_KEY1  = 3'b010,
      UL_ARMED = 3'b100
   } deeac_unlock_t;
endpackage

// ==== hw/deeac_top.sv ====
/*
 Data EEPROM access control: APB register file, unlock gate, byte read,
 erase-then-program write sequencer and completion interrupt.
 Assumes APB3 without wait states from the master side, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module deeac_top #(
   parameter int ADDR_W       = deeac_pkg::ADDR_W,
   parameter int ERASE_CYCLES = deeac_pkg::ERASE_CYCLES_DEF,
   parameter int PROG_CYCLES  = deeac_pkg::PROG_CYCLES_DEF
) (
   input  wire logic                          CLOCK,
   input  wire logic                          RST_B,
   input  wire logic                          PSEL,
   input  wire logic                          PENABLE,
   input  wire logic                          PWRITE,
   input  wire logic [deeac_pkg::PADDR_W-1:0] PADDR,
   input  wire logic [deeac_pkg::PDATA_W-1:0] PWDATA,
   output var  logic [deeac_pkg::PDATA_W-1:0] PRDATA,
   output var  logic                          PREADY,
   output var  logic                          PSLVERR,
   output var  logic                          IRQ
);
   localparam int ADHI_W = ADDR_W - deeac_pkg::ADRLO_W;
   localparam int DW     = deeac_pkg::DATA_W;
   localparam int CW     = deeac_pkg::CNT_W;

   logic                          rst_meta_reg;
   logic                          rst_sync_reg;
   logic                          rst_n;
   deeac_pkg::deeac_ctrl_t        ctrl_reg;
   deeac_pkg::deeac_ctrl_t        ctrl_wdata;
   logic [deeac_pkg::ADRLO_W-1:0] addr_lo_reg;
   logic [ADHI_W-1:0]             addr_hi_reg;
   logic [DW-1:0]                 data_reg;
   deeac_pkg::deeac_unlock_t      unlock_reg;
   deeac_pkg::deeac_state_t       state_reg;
   logic [CW-1:0]                 cnt_reg;
   logic                          mem_we_reg;
   logic [DW-1:0]                 mem_wdata_reg;
   logic [DW-1:0]                 mem_rdata;
   logic                          rd_land_reg;
   logic [deeac_pkg::EVT_N-1:0]   status_reg;
   logic [deeac_pkg::EVT_N-1:0]   mask_reg;
   logic [deeac_pkg::EVT_N-1:0]   evt_set;
   logic                          pready_reg;
   logic [deeac_pkg::PDATA_W-1:0] prdata_reg;
   logic                          pslverr_reg;
   logic                          irq_reg;
   logic [deeac_pkg::PDATA_W-1:0] rd_mux;
   logic                          rd_mapped;
   logic                          setup;
   logic                          wr_acc;
   logic                          busy;
   logic                          ctrl_write;
   logic                          wr_start;
   logic                          wr_refused;
   logic                          rd_start;
   logic                          write_done;

   function automatic logic hit(
      input logic [deeac_pkg::PADDR_W-1:0] a,
      input logic [deeac_pkg::PADDR_W-1:0] off
   );
      return a == off;
   endfunction

   // Reset release through two flops
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   assign setup  = PSEL & ~PENABLE;
   assign wr_acc = PSEL & PENABLE & pready_reg & PWRITE;
   assign busy   = state_reg != deeac_pkg::ST_IDLE;
   assign ctrl_wdata = deeac_pkg::deeac_ctrl_t'(PWDATA[deeac_pkg::CTRL_W-1:0]);

   // Locked registers ignore writes while a write cycle runs
   assign ctrl_write = wr_acc & hit(PADDR, deeac_pkg::OFF_CTRL) & ~busy;

   // Request needs the unlock, an enable already set, region zero
   assign wr_start = ctrl_write & ctrl_wdata.wr_req
                   & ctrl_reg.write_enable_bit
                   & (unlock_reg == deeac_pkg::UL_ARMED)
                   & (ctrl_wdata.region == deeac_pkg::REGION_EEPROM);
   assign wr_refused = ctrl_write & ctrl_wdata.wr_req & ~wr_start;
   assign rd_start = ctrl_write & ctrl_wdata.rd_req & ~ctrl_wdata.wr_req
                   & (ctrl_wdata.region == deeac_pkg::REGION_EEPROM);
   assign write_done = (state_reg == deeac_pkg::ST_PROG)
                     & (cnt_reg == '0);

   // Control register; hardware only ever clears the request bits
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= deeac_pkg::CTRL_RESET;
      end else if (ctrl_write) begin
         ctrl_reg.region           <= ctrl_wdata.region;
         ctrl_reg.erase_req        <= ctrl_wdata.erase_req;
         ctrl_reg.write_enable_bit <= ctrl_wdata.write_enable_bit;
         ctrl_reg.wr_req           <= wr_start;
         ctrl_reg.rd_req           <= rd_start;
      end else begin
         if (rd_land_reg) begin
            ctrl_reg.rd_req <= 1'b0;
         end
         if (write_done) begin
            ctrl_reg.wr_req <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         addr_lo_reg <= '0;
      end else if (wr_acc & hit(PADDR, deeac_pkg::OFF_ADDR_LO) & ~busy) begin
         addr_lo_reg <= PWDATA[deeac_pkg::ADRLO_W-1:0];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         addr_hi_reg <= '0;
      end else if (wr_acc & hit(PADDR, deeac_pkg::OFF_ADDR_HI) & ~busy) begin
         addr_hi_reg <= PWDATA[ADHI_W-1:0];
      end
   end

   // Data holds until a read lands or software loads it
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= '0;
      end else if (wr_acc & hit(PADDR, deeac_pkg::OFF_DATA) & ~busy) begin
         data_reg <= PWDATA[DW-1:0];
      end else if (rd_land_reg) begin
         data_reg <= mem_rdata;
      end
   end

   // Two key writes back to back arm one control write; any write disarms
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         unlock_reg <= deeac_pkg::UL_NONE;
      end else if (wr_acc) begin
         if (hit(PADDR, deeac_pkg::OFF_UNLOCK)
             && PWDATA[DW-1:0] == deeac_pkg::UNLOCK_KEY1) begin
            unlock_reg <= deeac_pkg::UL_KEY1;
         end else if (hit(PADDR, deeac_pkg::OFF_UNLOCK)
                      && PWDATA[DW-1:0] == deeac_pkg::UNLOCK_KEY2
                      && unlock_reg == deeac_pkg::UL_KEY1) begin
            unlock_reg <= deeac_pkg::UL_ARMED;
         end else begin
            unlock_reg <= deeac_pkg::UL_NONE;
         end
      end
   end

   // Read: array sampled at the access edge, result bypassed to the bus
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         rd_land_reg <= 1'b0;
      end else begin
         rd_land_reg <= rd_start;
      end
   end

   // Write sequencer: erase to blank, then program; bus stays free
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= deeac_pkg::ST_IDLE;
         cnt_reg       <= '0;
         mem_we_reg    <= 1'b0;
         mem_wdata_reg <= '0;
      end else begin
         mem_we_reg <= 1'b0;
         case (state_reg)
            deeac_pkg::ST_IDLE: begin
               if (wr_start) begin
                  state_reg     <= deeac_pkg::ST_ERASE;
                  cnt_reg       <= CW'(ERASE_CYCLES - 1);
                  mem_we_reg    <= 1'b1;
                  mem_wdata_reg <= deeac_pkg::ERASED_BYTE;
               end
            end
            deeac_pkg::ST_ERASE: begin
               // Enable bit not looked at once started
               if (cnt_reg == '0) begin
                  state_reg     <= deeac_pkg::ST_PROG;
                  cnt_reg       <= CW'(PROG_CYCLES - 1);
                  mem_we_reg    <= 1'b1;
                  mem_wdata_reg <= data_reg;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            deeac_pkg::ST_PROG: begin
               if (cnt_reg == '0) begin
                  state_reg <= deeac_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= deeac_pkg::ST_IDLE;
            end
         endcase
      end
   end

   deeac_mem #(
      .AW (ADDR_W),
      .DW (DW)
   ) u_mem (
      .clk     (CLOCK),
      .wr_en   (mem_we_reg),
      .rd_en   (rd_start),
      .addr    ({addr_hi_reg, addr_lo_reg}),
      .wr_data (mem_wdata_reg),
      .rd_data (mem_rdata)
   );

   // Sticky events: set wins over the write-one clear
   assign evt_set[deeac_pkg::EVT_DONE]    = write_done;
   assign evt_set[deeac_pkg::EVT_REFUSED] = wr_refused;

   generate
      for (genvar i = 0; i < deeac_pkg::EVT_N; i++) begin : g_evt
         always_ff @(posedge CLOCK or negedge rst_n) begin
            if (!rst_n) begin
               status_reg[i] <= 1'b0;
            end else if (evt_set[i]) begin
               status_reg[i] <= 1'b1;
            end else if (wr_acc & hit(PADDR, deeac_pkg::OFF_STATUS)
                         & PWDATA[i]) begin
               status_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= deeac_pkg::EVT_RESET;
      end else if (wr_acc & hit(PADDR, deeac_pkg::OFF_MASK)) begin
         mask_reg <= PWDATA[deeac_pkg::EVT_N-1:0];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   always_comb begin
      rd_mux    = '0;
      rd_mapped = 1'b1;
      case (PADDR)
         deeac_pkg::OFF_ADDR_LO: rd_mux = 32'(addr_lo_reg);
         deeac_pkg::OFF_ADDR_HI: rd_mux = 32'(addr_hi_reg);
         deeac_pkg::OFF_CTRL:    rd_mux = 32'(ctrl_reg);
         deeac_pkg::OFF_DATA: begin
            rd_mux = rd_land_reg ? 32'(mem_rdata) : 32'(data_reg);
         end
         deeac_pkg::OFF_UNLOCK:  rd_mux = '0;
         deeac_pkg::OFF_STATUS:  rd_mux = 32'({busy, status_reg});
         deeac_pkg::OFF_MASK:    rd_mux = 32'(mask_reg);
         default:                rd_mapped = 1'b0;
      endcase
   end

   // Fixed two-cycle transfer: answer prepared in the setup cycle
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~rd_mapped;
         if (setup & ~PWRITE) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   assign PREADY  = pready_reg;
   assign PRDATA  = prdata_reg;
   assign PSLVERR = pslverr_reg;
   assign IRQ     = irq_reg;
endmodule
`default_nettype wire

// ==== sim/deeac_checker.sv ====
/*
 Concurrent checks on the bus and interrupt ports of deeac_top.
 Assumes it is bound to deeac_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module deeac_checker (
   input wire logic        CLOCK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   logic       acc;
   logic       wsm;
   logic       rdd;
   logic       seen_reg;
   logic       dirty_reg;
   logic [1:0] mask_reg;
   logic [7:0] last_reg;
   assign acc = PSEL && PENABLE && PREADY;
   assign wsm = acc && PWRITE && (PADDR == deeac_pkg::OFF_STATUS ||
                PADDR == deeac_pkg::OFF_MASK);
   assign rdd = acc && !PWRITE && PADDR == deeac_pkg::OFF_DATA;
   // Shadow of mask and of the last data register read
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         mask_reg <= 2'h0;
         last_reg <= 8'h00;
         seen_reg <= 1'b0;
         dirty_reg <= 1'b0;
      end else if (acc && PWRITE) begin
         if (PADDR == deeac_pkg::OFF_MASK)
            mask_reg <= PWDATA[1:0];
         if (PADDR == deeac_pkg::OFF_DATA || PADDR == deeac_pkg::OFF_CTRL)
            dirty_reg <= 1'b1;
      end else if (rdd) begin
         last_reg <= PRDATA[7:0];
         seen_reg <= 1'b1;
         dirty_reg <= 1'b0;
      end
   end
   property p_ready_next;
      PSEL && !PENABLE |=> PREADY;
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("No ready after setup");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("Ready longer than one cycle");
   property p_unmapped;
      PSEL && !PENABLE && PADDR > deeac_pkg::OFF_MASK
         |=> PSLVERR && (PWRITE || PRDATA == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped access not flagged");
   property p_irq_masked;
      mask_reg == 2'h0 |=> !IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("Interrupt while all masked");
   property p_irq_holds;
      IRQ && !wsm && !$past(wsm) |=> IRQ;
   endproperty
   a_irq_holds: assert property (p_irq_holds)
      else $error("Interrupt dropped without clear");
   property p_data_holds;
      rdd && seen_reg && !dirty_reg |-> PRDATA[7:0] == last_reg;
   endproperty
   a_data_holds: assert property (p_data_holds)
      else $error("Data register changed by itself");
   property p_rd_clear;
      acc && !PWRITE && PADDR == deeac_pkg::OFF_CTRL |-> !PRDATA[0];
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("Read request still set");
   property p_upper_zero;
      acc && !PWRITE |-> PRDATA[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("Upper read bits not zero");
   c_irq: cover property (IRQ);
   c_err: cover property (acc && PSLVERR);
   c_hold: cover property (rdd && seen_reg && !dirty_reg);
endmodule
bind deeac_top deeac_checker deeac_checker_i (
   .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
`default_nettype wire

// ==== sim/deeac_tb_top.sv ====
/*
 Self-checking bench of the data EEPROM access control block.
 Assumes deeac_top built with short erase and program counts.
*/
`timescale 1ns/1ps
`default_nettype none
module deeac_tb_top;
   logic        CLOCK = 1'b0;
   logic        RST_B = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        IRQ;
   logic [32:0] exp_q[$];
   logic [7:0]  lo;
   logic [7:0]  dat;
   logic [31:0] pre[4] = '{32'h0, 32'h0, 32'h4, 32'h4};
   logic [31:0] req[4] = '{32'h2, 32'h6, 32'h6, 32'h16};
   int          error_cnt = 0;
   int          comparisons = 0;
   int          n;
   logic        b2b = 1'b0;
   deeac_top #(.ERASE_CYCLES(20), .PROG_CYCLES(30)) deeac_top_i (
      .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
   initial begin
      forever #50 CLOCK = ~CLOCK;
   end
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_irq(input logic exp);
      comparisons++;
      if (IRQ !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, IRQ, exp);
      end
   endtask
   task automatic results;
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Monitor: each read answer against the oldest note
   always @(posedge CLOCK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
         cmp({PSLVERR, PRDATA}, exp_q.pop_front());
   end
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int k;
      k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1 && k < 20) begin
         @(posedge CLOCK);
         k++;
      end
      if (k == 20) begin
         error_cnt++;
         results();
      end
      // Back to back: next setup follows the access at once
      if (b2b) begin
         PENABLE <= 1'b0;
      end else begin
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         @(posedge CLOCK);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic unl;
      wr(deeac_pkg::OFF_UNLOCK, {24'h0, deeac_pkg::UNLOCK_KEY1});
      wr(deeac_pkg::OFF_UNLOCK, {24'h0, deeac_pkg::UNLOCK_KEY2});
   endtask
   initial begin
      #(3000 * 100);
      error_cnt++;
      results();
   end
   initial begin
      void'($urandom(79));
      repeat (12) @(posedge CLOCK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLOCK);
      rd(deeac_pkg::OFF_CTRL, 33'h0);
      rd(deeac_pkg::OFF_UNLOCK, 33'h0);
      rd(8'h1c, 33'h100000000);
      lo = 8'($urandom);
      dat = 8'($urandom);
      wr(deeac_pkg::OFF_ADDR_LO, {24'h0, lo});
      wr(deeac_pkg::OFF_ADDR_HI, 32'($urandom & 3));
      wr(deeac_pkg::OFF_DATA, {24'h0, dat});
      wr(deeac_pkg::OFF_CTRL, 32'h2);
      rd(deeac_pkg::OFF_STATUS, 33'h2);
      cmp_irq(1'b0);
      wr(deeac_pkg::OFF_STATUS, 32'h2);
      wr(deeac_pkg::OFF_MASK, 32'h1);
      wr(deeac_pkg::OFF_CTRL, 32'h4);
      unl();
      wr(deeac_pkg::OFF_CTRL, 32'h6);
      rd(deeac_pkg::OFF_STATUS, 33'h4);
      wr(deeac_pkg::OFF_ADDR_LO, {24'h0, ~lo});
      wr(deeac_pkg::OFF_CTRL, 32'h0);
      wr(deeac_pkg::OFF_DATA, {24'h0, ~dat});
      rd(deeac_pkg::OFF_ADDR_LO, {25'h0, lo});
      rd(deeac_pkg::OFF_CTRL, 33'h6);
      n = 0;
      while (IRQ !== 1'b1 && n < 100) begin
         @(posedge CLOCK);
         n++;
      end
      cmp_irq(1'b1);
      rd(deeac_pkg::OFF_STATUS, 33'h1);
      rd(deeac_pkg::OFF_CTRL, 33'h4);
      cmp_irq(1'b1);
      wr(deeac_pkg::OFF_STATUS, 32'h1);
      rd(deeac_pkg::OFF_STATUS, 33'h0);
      cmp_irq(1'b0);
      b2b = 1'b1;
      wr(deeac_pkg::OFF_CTRL, 32'h5);
      b2b = 1'b0;
      rd(deeac_pkg::OFF_DATA, {25'h0, dat});
      rd(deeac_pkg::OFF_CTRL, 33'h4);
      rd(deeac_pkg::OFF_DATA, {25'h0, dat});
      wr(deeac_pkg::OFF_MASK, 32'h2);
      for (int i = 0; i < 4; i++) begin
         wr(deeac_pkg::OFF_CTRL, pre[i]);
         if (i != 2)
            unl();
         wr(deeac_pkg::OFF_CTRL, req[i]);
         rd(deeac_pkg::OFF_STATUS, 33'h2);
         cmp_irq(1'b1);
         wr(deeac_pkg::OFF_STATUS, 32'h2);
      end
      rd(deeac_pkg::OFF_ADDR_LO, {25'h0, lo});
      results();
   end
endmodule
`default_nettype wire
